// file: hw/sie_defs.svh
// sie_defs.svh - register offsets, field positions, reset values and timing figures
// assumes a 32-bit apb slave with 12-bit byte address and a 200 MHz pclk
`ifndef SIE_DEFS_SVH
`define SIE_DEFS_SVH

// clock rate and documented lamp / muting times, each in its own unit
`define SIE_CLK_HZ        200000000
`define SIE_SLOW_HZ       1
`define SIE_FAST_HZ       10
`define SIE_ALT_HZ        2
`define SIE_SIM_S         4

// register byte offsets
`define SIE_OFF_CTRL      12'h000
`define SIE_OFF_STATE     12'h004
`define SIE_OFF_IRQ_STAT  12'h008
`define SIE_OFF_IRQ_MASK  12'h00c
`define SIE_OFF_INTERF    12'h010

// control register: lamp enable, muting-capable variant
`define SIE_CTRL_W        2
`define SIE_CTRL_RST      2'h3
`define SIE_CTRL_EN_BIT   0
`define SIE_CTRL_MUTE_BIT 1

// interrupt status / mask layout
`define SIE_IRQ_W         3
`define SIE_IRQ_PAT_BIT   0
`define SIE_IRQ_MUTE_BIT  1
`define SIE_IRQ_FAULT_BIT 2
`define SIE_IRQ_MASK_RST  3'h0

// interference info width
`define SIE_INTERF_W      8
`endif

// file: hw/sie_pkg.sv
// sie_pkg.sv - types shared by the status indicator encoder
// assumes sie_defs.svh holds every number; this file holds only types
`default_nettype none
package sie_pkg;

    // lamp patterns, one per displayed receiver condition
    typedef enum logic [3:0] {
        SIE_PAT_OFF,
        SIE_PAT_GREEN,
        SIE_PAT_RED,
        SIE_PAT_ALT_YR,
        SIE_PAT_WHITE,
        SIE_PAT_FLASH_W,
        SIE_PAT_ALT_RW,
        SIE_PAT_SLOW_RED,
        SIE_PAT_FAST_RED,
        SIE_PAT_SLOW_GREEN
    } sie_pat_t;

    // one multicolour lamp, three emitters
    typedef struct packed {
        logic red;
        logic green;
        logic blue;
    } sie_rgb_t;

    // receiver state as delivered by the sequencer logic
    typedef struct packed {
        logic safe_out_on;   // requested safety switching output
        logic interlock;     // restart interlock locked
        logic muting_active; // muting sequence in progress
        logic muting_valid;  // muting condition valid
        logic mute_timeout;  // muting time limit exceeded
        logic device_err;
        logic wiring_err;
        logic internal_err;
        logic weak_signal;
    } sie_state_t;

endpackage
`default_nettype wire

// file: hw/sie_flash_gen.sv
// sie_flash_gen.sv - free running flash phase divider
// assumes one pclk domain; phase toggles every HALF cycles
`timescale 1ns/1ps
`default_nettype none
module sie_flash_gen #(
    parameter int unsigned HALF = 100000000
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      phase
);
    logic [31:0] cnt_r; // cycles into current half period

    // count one half period, then flip the phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 32'h0;
            phase <= 1'b0;
        end else if (cnt_r == 32'(HALF - 1)) begin
            cnt_r <= 32'h0;
            phase <= ~phase;
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end
endmodule
`default_nettype wire

// file: hw/sie_mute_check.sv
// sie_mute_check.sv - simultaneity check of the two muting signals
// assumes muting signals already synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
module sie_mute_check #(
    parameter int unsigned SIM_CYC = 800000000
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic sig_a,
    input  wire logic sig_b,
    output logic      sim_err,
    output logic      err_pulse
);
    typedef enum logic [1:0] {SIE_MC_IDLE, SIE_MC_WAIT, SIE_MC_BOTH, SIE_MC_ERR} sie_mc_t;
    sie_mc_t     st_r;  // checker state
    logic [31:0] cnt_r; // cycles since first signal came

    // first signal starts the window, the second must follow inside it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r      <= SIE_MC_IDLE;
            cnt_r     <= 32'h0;
            err_pulse <= 1'b0;
        end else begin
            err_pulse <= 1'b0;
            unique case (st_r)
                SIE_MC_IDLE: begin
                    cnt_r <= 32'h0;
                    if (sig_a && sig_b)      st_r <= SIE_MC_BOTH;
                    else if (sig_a || sig_b) st_r <= SIE_MC_WAIT;
                end
                SIE_MC_WAIT: begin
                    cnt_r <= cnt_r + 32'h1;
                    if (sig_a && sig_b) begin
                        st_r <= SIE_MC_BOTH;
                    end else if (!(sig_a || sig_b)) begin
                        st_r <= SIE_MC_IDLE; // withdrawn, no error
                    end else if (cnt_r == 32'(SIM_CYC - 1)) begin
                        st_r      <= SIE_MC_ERR; // R7
                        err_pulse <= 1'b1;
                    end
                end
                // error holds until both signals fall, so the lamp stays readable
                SIE_MC_BOTH, SIE_MC_ERR: begin
                    if (!(sig_a || sig_b)) st_r <= SIE_MC_IDLE;
                end
            endcase
        end
    end

    assign sim_err = (st_r == SIE_MC_ERR);

    // error flagged exactly when the window runs out with one signal alone
    property p_sim_window;
        @(posedge pclk) disable iff (!presetn)
        (st_r == SIE_MC_WAIT && cnt_r == 32'(SIM_CYC - 1) && (sig_a ^ sig_b)) |=> (sim_err && err_pulse);
    endproperty
    a_sim_window: assert property (p_sim_window) else $error("muting simultaneity error missed"); // R7
endmodule
`default_nettype wire

// file: hw/sie_top.sv
// sie_top.sv - status indicator encoder for a light-beam safety receiver
// assumes an apb master on pclk, receiver state synchronous to pclk
//
// Functional notes
// R1 - green steady: output on, no muting, healthy
// R2 - red steady: output off, nothing else pending
// R3 - interlock locked: yellow/red alternate, operator resets
// R4 - muting variant: white steady, on, muting valid
// R5 - on with muting error: white flashing
// R6 - off with muting error: red/white alternate
// R7 - muting signals over 4 s apart: error
// R8 - muting timeout counts as muting error
// R9 - device/wiring error: output off, red 1 Hz
// R10 - internal error: output off, red 10 Hz
// R11 - on with weak signal: green 1 Hz
// R12 - interference info readable by fieldbus master
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "sie_defs.svh"
`default_nettype none
module sie_top
    import sie_pkg::*;
#(
    parameter int unsigned SLOW_HALF = `SIE_CLK_HZ / (2 * `SIE_SLOW_HZ),
    parameter int unsigned FAST_HALF = `SIE_CLK_HZ / (2 * `SIE_FAST_HZ),
    parameter int unsigned ALT_HALF  = `SIE_CLK_HZ / (2 * `SIE_ALT_HZ),
    parameter int unsigned SIM_CYC   = `SIE_SIM_S * `SIE_CLK_HZ
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire sie_state_t               rx_state,
    input  wire logic                     mute_sig_a,
    input  wire logic                     mute_sig_b,
    input  wire logic [`SIE_INTERF_W-1:0] interf_info,
    input  wire logic                     param_rd,
    output logic [`SIE_INTERF_W-1:0]      interference_info_parameter,
    output logic                          param_valid,
    output sie_rgb_t                      lamp,
    output logic                          safety_switching_output,
    output logic                          irq
);
    localparam sie_rgb_t COL_OFF    = '{1'b0, 1'b0, 1'b0};
    localparam sie_rgb_t COL_RED    = '{1'b1, 1'b0, 1'b0};
    localparam sie_rgb_t COL_GREEN  = '{1'b0, 1'b1, 1'b0};
    localparam sie_rgb_t COL_YELLOW = '{1'b1, 1'b1, 1'b0};
    localparam sie_rgb_t COL_WHITE  = '{1'b1, 1'b1, 1'b1};

    // registers
    logic [`SIE_CTRL_W-1:0]    ctrl_r;      // lamp enable, muting variant
    logic [`SIE_IRQ_W-1:0]     irq_stat_r;  // sticky events
    logic [`SIE_IRQ_W-1:0]     irq_mask_r;  // event enables
    logic [`SIE_IRQ_W-1:0]     irq_stat_nxt;
    logic [`SIE_INTERF_W-1:0]  interf_r;    // latest interference info
    sie_pat_t                  pat_r;       // shown pattern
    sie_pat_t                  pat_nxt;
    sie_rgb_t                  lamp_r;
    sie_rgb_t                  lamp_nxt;
    logic                      ss_out_r;    // safety switching output
    logic                      fault_d_r;   // fault seen last cycle
    logic [31:0]               prdata_r;
    logic [31:0]               rd_nxt;
    logic                      pready_r;
    logic                      pslverr_r;
    logic                      irq_r;
    logic [`SIE_INTERF_W-1:0]  param_data_r;
    logic                      param_valid_r;

    // helper terms
    logic                      slow_ph;     // 1 Hz phase
    logic                      fast_ph;     // 10 Hz phase
    logic                      alt_ph;      // alternate phase
    logic                      sim_err;     // simultaneity error held
    logic                      sim_pulse;   // simultaneity error event
    logic                      any_fault;
    logic                      dev_fault;
    logic                      mute_var;
    logic                      lamp_en;
    logic                      mute_err;
    logic                      mute_on;
    logic                      addr_ok;
    logic                      setup_ph;
    logic                      wr_acc;
    logic [`SIE_IRQ_W-1:0]     irq_ev;
    logic [`SIE_IRQ_W-1:0]     irq_clr;

    // flash phase dividers, free running so patterns look steady
    sie_flash_gen #(.HALF(SLOW_HALF)) u_slow (
        .pclk    (pclk),
        .presetn (presetn),
        .phase   (slow_ph)
    );
    sie_flash_gen #(.HALF(FAST_HALF)) u_fast (
        .pclk    (pclk),
        .presetn (presetn),
        .phase   (fast_ph)
    );
    sie_flash_gen #(.HALF(ALT_HALF)) u_alt (
        .pclk    (pclk),
        .presetn (presetn),
        .phase   (alt_ph)
    );

    // muting simultaneity watchdog
    sie_mute_check #(.SIM_CYC(SIM_CYC)) u_mute (
        .pclk      (pclk),
        .presetn   (presetn),
        .sig_a     (mute_sig_a),
        .sig_b     (mute_sig_b),
        .sim_err   (sim_err),
        .err_pulse (sim_pulse)
    );

    // condition decode
    assign dev_fault = rx_state.device_err | rx_state.wiring_err;
    assign any_fault = dev_fault | rx_state.internal_err;
    assign mute_var  = ctrl_r[`SIE_CTRL_MUTE_BIT];
    assign lamp_en   = ctrl_r[`SIE_CTRL_EN_BIT];
    // timeout, late second signal or an invalid condition all read as error
    assign mute_err  = sim_err | rx_state.mute_timeout // R7 R8
                     | (rx_state.muting_active & ~rx_state.muting_valid);
    assign mute_on   = rx_state.muting_active & rx_state.muting_valid;

    // pattern selection, faults first so a broken unit never looks healthy
    always_comb begin
        pat_nxt = SIE_PAT_RED;
        if (rx_state.internal_err) begin
            pat_nxt = SIE_PAT_FAST_RED; // R10
        end else if (dev_fault) begin
            pat_nxt = SIE_PAT_SLOW_RED; // R9
        end else if (rx_state.interlock) begin
            pat_nxt = SIE_PAT_ALT_YR; // R3
        end else if (mute_var && mute_err) begin
            pat_nxt = rx_state.safe_out_on ? SIE_PAT_FLASH_W : SIE_PAT_ALT_RW; // R5 R6 R8
        end else if (mute_var && mute_on && rx_state.safe_out_on) begin
            pat_nxt = SIE_PAT_WHITE; // R4
        end else if (rx_state.safe_out_on && rx_state.weak_signal) begin
            pat_nxt = SIE_PAT_SLOW_GREEN; // R11
        end else if (rx_state.safe_out_on) begin
            pat_nxt = SIE_PAT_GREEN; // R1
        end else begin
            pat_nxt = SIE_PAT_RED; // R2
        end
    end

    // pattern to colour, phases pick the half of each flash or alternation
    always_comb begin
        lamp_nxt = COL_OFF;
        unique case (pat_r)
            SIE_PAT_OFF:        lamp_nxt = COL_OFF;
            SIE_PAT_GREEN:      lamp_nxt = COL_GREEN; // R1
            SIE_PAT_RED:        lamp_nxt = COL_RED; // R2
            SIE_PAT_ALT_YR:     lamp_nxt = alt_ph ? COL_YELLOW : COL_RED; // R3
            SIE_PAT_WHITE:      lamp_nxt = COL_WHITE; // R4
            SIE_PAT_FLASH_W:    lamp_nxt = alt_ph ? COL_WHITE : COL_OFF; // R5
            SIE_PAT_ALT_RW:     lamp_nxt = alt_ph ? COL_RED : COL_WHITE; // R6
            SIE_PAT_SLOW_RED:   lamp_nxt = slow_ph ? COL_RED : COL_OFF; // R9
            SIE_PAT_FAST_RED:   lamp_nxt = fast_ph ? COL_RED : COL_OFF; // R10
            SIE_PAT_SLOW_GREEN: lamp_nxt = slow_ph ? COL_GREEN : COL_OFF; // R11
            default:            lamp_nxt = COL_RED; // illegal code shows red, never green
        endcase
    end

    // pattern and lamp registers; lamp dark while software disables it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pat_r  <= SIE_PAT_OFF;
            lamp_r <= COL_OFF;
        end else begin
            pat_r  <= pat_nxt;
            lamp_r <= lamp_en ? lamp_nxt : COL_OFF;
        end
    end

    // safety switching output forced off by any fault, whatever software says
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ss_out_r <= 1'b0;
        end else begin
            ss_out_r <= rx_state.safe_out_on & ~any_fault; // R9 R10
        end
    end

    // interference info capture and fieldbus parameter port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interf_r      <= '0;
            param_data_r  <= '0;
            param_valid_r <= 1'b0;
        end else begin
            interf_r      <= interf_info;
            param_valid_r <= param_rd; // R12
            if (param_rd) begin
                param_data_r <= interf_r; // R12
            end
        end
    end

    // apb decode: answer in the first access cycle
    assign addr_ok  = (paddr == `SIE_OFF_CTRL) || (paddr == `SIE_OFF_STATE)
                   || (paddr == `SIE_OFF_IRQ_STAT) || (paddr == `SIE_OFF_IRQ_MASK)
                   || (paddr == `SIE_OFF_INTERF);
    assign setup_ph = psel & ~penable;
    assign wr_acc   = psel & penable & pready_r & pwrite & ~pslverr_r;

    // read mux, sampled at the setup edge
    always_comb begin
        rd_nxt = 32'h0;
        unique case (paddr)
            `SIE_OFF_CTRL:     rd_nxt = {30'h0, ctrl_r};
            `SIE_OFF_STATE:    rd_nxt = {13'h0, pat_r, 1'b0, lamp_r, ss_out_r, sim_err, rx_state};
            `SIE_OFF_IRQ_STAT: rd_nxt = {29'h0, irq_stat_r};
            `SIE_OFF_IRQ_MASK: rd_nxt = {29'h0, irq_mask_r};
            `SIE_OFF_INTERF:   rd_nxt = {24'h0, interf_r}; // R12
            default:           rd_nxt = 32'h0; // unmapped reads zero
        endcase
    end

    // bus handshake and read data; unmapped address answers with slverr
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else begin
            pready_r  <= setup_ph;
            pslverr_r <= setup_ph & ~addr_ok;
            if (setup_ph && !pwrite) begin
                prdata_r <= rd_nxt;
            end
        end
    end

    // control and mask writes take effect at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= `SIE_CTRL_RST;
            irq_mask_r <= `SIE_IRQ_MASK_RST;
        end else if (wr_acc) begin
            if (paddr == `SIE_OFF_CTRL)     ctrl_r     <= pwdata[`SIE_CTRL_W-1:0];
            if (paddr == `SIE_OFF_IRQ_MASK) irq_mask_r <= pwdata[`SIE_IRQ_W-1:0];
        end
    end

    // events: pattern change, muting window miss, fault onset
    always_comb begin
        irq_ev                     = '0;
        irq_ev[`SIE_IRQ_PAT_BIT]   = (pat_nxt != pat_r);
        irq_ev[`SIE_IRQ_MUTE_BIT]  = sim_pulse;
        irq_ev[`SIE_IRQ_FAULT_BIT] = any_fault & ~fault_d_r;
        irq_clr                    = (wr_acc && paddr == `SIE_OFF_IRQ_STAT) ? pwdata[`SIE_IRQ_W-1:0] : '0;
        // set wins so an event in the clearing cycle is kept
        irq_stat_nxt               = (irq_stat_r & ~irq_clr) | irq_ev;
    end

    // sticky status and level interrupt, one cycle behind the status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= '0;
            fault_d_r  <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            fault_d_r  <= any_fault;
            irq_r      <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign prdata                      = prdata_r;
    assign pready                      = pready_r;
    assign pslverr                     = pslverr_r;
    assign lamp                        = lamp_r;
    assign safety_switching_output     = ss_out_r;
    assign irq                         = irq_r;
    assign interference_info_parameter = param_data_r;
    assign param_valid                 = param_valid_r;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // healthy on state with no muting or weak signal
    sequence s_green_cause;
        rx_state.safe_out_on && !any_fault && !rx_state.interlock && !rx_state.weak_signal
            && !(mute_var && (mute_err || mute_on));
    endsequence
    // pattern first, then the colour one cycle later
    property p_green;
        s_green_cause |=> (pat_r == SIE_PAT_GREEN) ##1 (!$past(lamp_en) || lamp_r == COL_GREEN);
    endproperty
    a_green: assert property (p_green) else $error("green steady not shown"); // R1

    property p_red;
        (!rx_state.safe_out_on && !any_fault && !rx_state.interlock && !(mute_var && mute_err))
            |=> (pat_r == SIE_PAT_RED) ##1 (!$past(lamp_en) || lamp_r == COL_RED);
    endproperty
    a_red: assert property (p_red) else $error("red steady not shown"); // R2

    property p_interlock;
        (rx_state.interlock && !any_fault)
            |=> (pat_r == SIE_PAT_ALT_YR) ##1 (!$past(lamp_en) || lamp_r == COL_YELLOW || lamp_r == COL_RED);
    endproperty
    a_interlock: assert property (p_interlock) else $error("interlock colours wrong"); // R3

    property p_white;
        (mute_var && mute_on && !mute_err && rx_state.safe_out_on && !any_fault && !rx_state.interlock)
            |=> pat_r == SIE_PAT_WHITE;
    endproperty
    a_white: assert property (p_white) else $error("muting white not shown"); // R4

    property p_flash_white;
        (pat_r == SIE_PAT_FLASH_W && lamp_en) |=> (lamp_r == COL_WHITE || lamp_r == COL_OFF);
    endproperty
    a_flash_white: assert property (p_flash_white) else $error("white flash colour wrong"); // R5

    property p_alt_rw;
        (mute_var && mute_err && !rx_state.safe_out_on && !any_fault && !rx_state.interlock)
            |=> (pat_r == SIE_PAT_ALT_RW) ##1 (!$past(lamp_en) || lamp_r == COL_RED || lamp_r == COL_WHITE);
    endproperty
    a_alt_rw: assert property (p_alt_rw) else $error("red/white alternation missing"); // R6

    property p_timeout;
        (mute_var && rx_state.mute_timeout && rx_state.safe_out_on && !any_fault && !rx_state.interlock)
            |=> pat_r == SIE_PAT_FLASH_W;
    endproperty
    a_timeout: assert property (p_timeout) else $error("muting timeout not shown as error"); // R8

    property p_dev_fault;
        (dev_fault && !rx_state.internal_err) |=> (pat_r == SIE_PAT_SLOW_RED && !safety_switching_output);
    endproperty
    a_dev_fault: assert property (p_dev_fault) else $error("device fault not handled"); // R9

    property p_int_fault;
        rx_state.internal_err |=> (pat_r == SIE_PAT_FAST_RED && !safety_switching_output);
    endproperty
    a_int_fault: assert property (p_int_fault) else $error("internal fault not handled"); // R10

    property p_weak;
        (rx_state.safe_out_on && rx_state.weak_signal && !any_fault && !rx_state.interlock
            && !(mute_var && (mute_err || mute_on)))
            |=> (pat_r == SIE_PAT_SLOW_GREEN) ##1 (!$past(lamp_en) || lamp_r == COL_GREEN || lamp_r == COL_OFF);
    endproperty
    a_weak: assert property (p_weak) else $error("weak signal flash missing"); // R11

    property p_param;
        param_rd |=> (param_valid && interference_info_parameter == $past(interf_r));
    endproperty
    a_param: assert property (p_param) else $error("parameter read data wrong"); // R12
endmodule
`default_nettype wire

// file: testbench/sie_fb_master.sv
// sie_fb_master.sv - fieldbus master model polling the interference parameter
// assumes one pclk domain; go is a one-cycle request from the bench
`timescale 1ns/1ps
`default_nettype none
module sie_fb_master (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic       param_valid,
    input  wire logic [7:0] param_data,
    output logic            param_rd,
    output logic [7:0]      got
);
    // one read strobe per request, answer captured on valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            param_rd <= 1'b0;
            got      <= 8'h00;
        end else begin
            param_rd <= go & ~param_rd;
            if (param_valid) begin
                got <= param_data;
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// tb.sv - self-checking bench for the status indicator encoder
// assumes sie_pkg and sie_defs.svh are compiled first; short flash dividers
`timescale 1ns/1ps
`include "sie_defs.svh"
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t mismatch", $time); end end
module tb import sie_pkg::*;;
    logic        pclk = 1'b0;        // 200 MHz bus clock
    logic        presetn = 1'b0;     // held low for 10 cycles
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    sie_state_t  rx_state = 9'h000;  // receiver condition under test
    logic        mute_sig_a = 1'b0;
    logic        mute_sig_b = 1'b0;
    logic [7:0]  interf_info = 8'h5a;
    logic        param_rd;
    logic [7:0]  param_data;
    logic        param_valid;
    sie_rgb_t    lamp;
    logic        safety_switching_output;
    logic        irq;
    logic        go = 1'b0;          // fieldbus poll request
    logic [7:0]  got;
    logic [31:0] rd;
    logic        er;
    int          mismatches = 0;
    int          checked = 0;
    int          cyc = 0;
    // condition table: state, expected pattern code, steady lamp (0 = flashing)
    logic [8:0]  st_tab [11] = '{9'h100, 9'h000, 9'h080, 9'h160, 9'h110, 9'h140,
                                 9'h010, 9'h108, 9'h004, 9'h102, 9'h101};
    logic [3:0]  code_tab [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h5, 4'h6, 4'h7, 4'h7, 4'h8, 4'h9};
    logic [2:0]  lamp_tab [11] = '{3'h2, 3'h4, 3'h0, 3'h7, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};

    sie_top #(.SLOW_HALF(20), .FAST_HALF(2), .ALT_HALF(10), .SIM_CYC(40)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_state(rx_state), .mute_sig_a(mute_sig_a), .mute_sig_b(mute_sig_b),
        .interf_info(interf_info), .param_rd(param_rd), .interference_info_parameter(param_data),
        .param_valid(param_valid), .lamp(lamp), .safety_switching_output(safety_switching_output),
        .irq(irq));

    sie_fb_master fb_u (.pclk(pclk), .presetn(presetn), .go(go), .param_valid(param_valid),
        .param_data(param_data), .param_rd(param_rd), .got(got));

    // clock and hang guard
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // one apb transfer; waits for pready, no fixed latency assumed
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `SIE_OFF_CTRL, 32'h0, rd, er);
        `CHK(rd, 32'h3)
        apb(1'b0, `SIE_OFF_IRQ_MASK, 32'h0, rd, er);
        `CHK(rd, 32'h0)
        apb(1'b0, 12'h020, 32'h0, rd, er);
        `CHK(er, 1'b1)
        // every displayed condition in turn
        for (int i = 0; i < 11; i++) begin
            @(posedge pclk) rx_state <= st_tab[i];
            repeat (4) @(posedge pclk);
            apb(1'b0, `SIE_OFF_STATE, 32'h0, rd, er);
            `CHK(rd[18:15], code_tab[i])
            `CHK(safety_switching_output, st_tab[i][8] & ~|st_tab[i][3:1])
            if (lamp_tab[i] != 3'h0) `CHK(lamp, lamp_tab[i])
        end
        // muting pair inside the window, then a lone signal
        @(posedge pclk) mute_sig_a <= 1'b1;
        repeat (10) @(posedge pclk);
        mute_sig_b <= 1'b1;
        repeat (50) @(posedge pclk);
        apb(1'b0, `SIE_OFF_STATE, 32'h0, rd, er);
        `CHK(rd[9], 1'b0)
        mute_sig_a <= 1'b0;
        mute_sig_b <= 1'b0;
        apb(1'b1, `SIE_OFF_IRQ_MASK, 32'h2, rd, er);
        mute_sig_a <= 1'b1;
        repeat (50) @(posedge pclk);
        apb(1'b0, `SIE_OFF_STATE, 32'h0, rd, er);
        `CHK(rd[9], 1'b1)
        `CHK(irq, 1'b1)
        mute_sig_a <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b1, `SIE_OFF_IRQ_STAT, 32'h7, rd, er);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b0, `SIE_OFF_IRQ_STAT, 32'h0, rd, er);
        `CHK(rd[1], 1'b0)
        // lamp switched off by software, then the plain variant ignores muting
        apb(1'b1, `SIE_OFF_CTRL, 32'h2, rd, er);
        repeat (3) @(posedge pclk);
        `CHK(lamp, 3'h0)
        apb(1'b1, `SIE_OFF_CTRL, 32'h1, rd, er);
        rx_state <= 9'h160;
        repeat (4) @(posedge pclk);
        apb(1'b0, `SIE_OFF_STATE, 32'h0, rd, er);
        `CHK(rd[18:15], 4'h1)
        `CHK(lamp, 3'h2)
        apb(1'b1, `SIE_OFF_CTRL, 32'h3, rd, er);
        apb(1'b0, `SIE_OFF_CTRL, 32'h0, rd, er);
        `CHK(rd, 32'h3)
        // fieldbus poll of the interference parameter
        go <= 1'b1;
        @(posedge pclk) go <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK(got, 8'h5a)
        apb(1'b0, `SIE_OFF_INTERF, 32'h0, rd, er);
        `CHK(rd[7:0], 8'h5a)
        print_verdict();
    end
endmodule
`default_nettype wire
